// [common/port8_pkg.sv]
// Purpose: Shared constants for the seven-pin multiplexed port
// Assumes: Byte-wide internal register bus with 16-bit addresses
// Notes:   Mode codes follow the operating-mode pins of the device
package port8_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [15:0] ADDR_DIRECTION   = 16'hFFBD;
    localparam logic [15:0] ADDR_DATA        = 16'hFFBF;

    // ****************************************************************
    // Reset values and fixed bits
    // ****************************************************************
    localparam logic [7:0]  DIR_RESET_EXP    = 8'h81;
    localparam logic [7:0]  DIR_RESET_SINGLE = 8'h80;
    localparam logic [7:0]  DATA_RESET       = 8'h80;
    localparam int          RESERVED_BIT     = 7;
    localparam logic        RESERVED_VALUE   = 1'b1;
    localparam logic [7:0]  DIR_READ_VALUE   = 8'hFF;

    // ****************************************************************
    // Operating modes
    // ****************************************************************
    localparam logic [1:0]  MODE_EXPANDED_1  = 2'h1;
    localparam logic [1:0]  MODE_EXPANDED_2  = 2'h2;
    localparam logic [1:0]  MODE_SINGLE      = 2'h3;

    // ****************************************************************
    // Pin positions
    // ****************************************************************
    localparam int          PIN_COUNT        = 7;
    localparam int          PIN_ECLK         = 0;
    localparam int          PIN_STROBE       = 1;
    localparam int          PIN_TX           = 4;
    localparam int          PIN_RX           = 5;
    localparam int          PIN_SCLK         = 6;
    localparam int          SELECT_COUNT     = 4;

endpackage : port8_pkg

// [logic/port8_pin_cell.sv]
// Purpose: Drive, level and pull-up decision for one port pin
// Assumes: Purely combinational; the caller registers the results
// Notes:   Priority is standby, peripheral output, peripheral input
`timescale 1ns/1ns
`default_nettype none

module port8_pin_cell (
    // Register bits for this pin
    input  wire logic dir_bit,
    input  wire logic data_bit,
    // Function selection
    input  wire logic func_out,
    input  wire logic func_val,
    input  wire logic func_in,
    input  wire logic gpio_out_ok,
    input  wire logic hw_standby,
    // Pin decision
    output logic      drive,
    output logic      level,
    output logic      pull_on
);

    // Pin mux, one pin
    always_comb begin
        drive   = 1'b0;
        level   = 1'b0;
        pull_on = 1'b0;
        if (hw_standby) begin
            drive   = 1'b0;                   // Float, pull-up off
            pull_on = 1'b0;
        end else if (func_out) begin
            drive   = 1'b1;                   // Peripheral owns pin
            level   = func_val;
            pull_on = 1'b0;
        end else if (func_in) begin
            pull_on = ~dir_bit & data_bit;    // Only pull-up kept
        end else if (dir_bit && gpio_out_ok) begin
            drive   = 1'b1;                   // Output pin
            level   = data_bit;
        end else begin
            pull_on = ~dir_bit & data_bit;    // Input pull-up
        end
    end

endmodule : port8_pin_cell

`default_nettype wire

// [logic/port8_pin_mux_gpio.sv]
// Purpose: Seven-pin general-purpose port with shared peripheral pins
// Assumes: Pin levels and peripheral controls synchronous to mclk
// Notes:   Pin outputs and peripheral inputs lag by one register stage
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Direction bit one makes pin output
// - Bit 7 ignores writes, reads one
// - Read: latch for outputs, pin for inputs
// - Input pin pull-up follows data bit
// - Expanded pin 0: E clock or input
// - Expanded pin 1: I/O strobe or input
// - Single-chip pins 0, 1: GPIO or select
// - Pins 2, 3: GPIO or slave select
// - Select inputs ignore bits except pull-up
// - Pin 4 transmit overrides bits, no pull-up
// - Pin 5 receive overrides bits except pull-up
// - Pin 6 serial clock; output has no pull-up, input pull-up follows data bit
// - Reset clears bits 6-1, pins input
// - Reset pin 0 direction depends on mode
// - Hardware standby floats pins, pull-ups off
// - Software standby: serial pins GPIO, E clock low
// - Direction write-only, reset 81 or 80
module port8_pin_mux_gpio
    import port8_pkg::*;
#(
    parameter int PINS = PIN_COUNT
) (
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst,
    // Operating state
    input  wire logic [1:0]              mode,
    input  wire logic                    dual_port_ram_enable,
    input  wire logic                    hw_standby,
    input  wire logic                    sw_standby,
    // Internal register bus
    input  wire logic [15:0]             addr,
    input  wire logic                    wr_stb,
    input  wire logic                    rd_stb,
    input  wire logic [7:0]              wdata,
    output logic      [7:0]              rdata,
    // Sources of alternate outputs
    input  wire logic                    e_clock,
    input  wire logic                    io_strobe_out,
    input  wire logic                    tx_enable,
    input  wire logic                    sync_serial_tx,
    input  wire logic                    rx_enable,
    input  wire logic                    sclk_out_enable,
    input  wire logic                    sclk_in_enable,
    input  wire logic                    sclk_out_level,
    // Port pins
    input  wire logic [PINS-1:0]         pin_in,
    output logic      [PINS-1:0]         pin_out,
    output logic      [PINS-1:0]         pin_oe_n,
    output logic      [PINS-1:0]         pin_pullup,
    // Alternate inputs to other blocks
    output logic      [SELECT_COUNT-1:0] slave_reg_select,
    output logic                         sync_serial_rx,
    output logic                         sync_serial_clock,
    output logic                         ext_interrupt_3,
    output logic                         ext_interrupt_4,
    output logic                         ext_interrupt_5
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [PINS-1:0]         dir_q;
    logic [PINS-1:0]         data_q;
    logic                    expanded;
    logic                    slave;
    logic                    serial_live;
    logic [PINS-1:0]         func_out;
    logic [PINS-1:0]         func_val;
    logic [PINS-1:0]         func_in;
    logic [PINS-1:0]         gpio_ok;
    logic [PINS-1:0]         cell_drive;
    logic [PINS-1:0]         cell_level;
    logic [PINS-1:0]         cell_pullup;
    logic [PINS-1:0]         pin_out_q;
    logic [PINS-1:0]         pin_out_d;
    logic [PINS-1:0]         pin_oe_n_q;
    logic [PINS-1:0]         pin_oe_n_d;
    logic [PINS-1:0]         pin_pullup_q;
    logic [PINS-1:0]         pin_pullup_d;
    logic [7:0]              rdata_q;
    logic [7:0]              rdata_d;
    logic [SELECT_COUNT-1:0] select_q;
    logic [SELECT_COUNT-1:0] select_d;
    logic                    rx_q;
    logic                    rx_d;
    logic                    sclk_q;
    logic                    sclk_d;
    logic [2:0]              irq_q;
    logic [2:0]              irq_d;

    // ****************************************************************
    // Elaboration check
    // ****************************************************************
    if (PINS != PIN_COUNT) begin : g_check
        $error("port8_pin_mux_gpio: PINS must equal PIN_COUNT");
    end

    // ****************************************************************
    // Registers
    // ****************************************************************

    // Direction and data latches
    port8_regs #(
        .PINS   (PINS)
    ) u_regs (
        .mclk   (mclk),
        .rst    (rst),
        .mode   (mode),
        .wr_stb (wr_stb),
        .addr   (addr),
        .wdata  (wdata),
        .dir_q  (dir_q),
        .data_q (data_q)
    );

    // ****************************************************************
    // Function selection
    // ****************************************************************

    // Operating state decode
    always_comb begin
        expanded    = (mode == MODE_EXPANDED_1)
                   || (mode == MODE_EXPANDED_2);
        slave       = (mode == MODE_SINGLE) && dual_port_ram_enable;
        serial_live = ~sw_standby;           // Serial drops out
    end

    // Per-pin ownership
    always_comb begin
        func_out = '0;
        func_val = '0;
        func_in  = '0;
        gpio_ok  = '1;
        // Pin 0: E clock, select 0 or plain port
        if (expanded) begin
            gpio_ok[PIN_ECLK]  = 1'b0;
            func_out[PIN_ECLK] = dir_q[PIN_ECLK];
            func_val[PIN_ECLK] = e_clock & ~sw_standby;  // Low
        end else if (slave) begin
            func_in[PIN_ECLK]  = 1'b1;
        end
        // Pin 1: I/O strobe, select 1 or plain port
        if (expanded) begin
            gpio_ok[PIN_STROBE]  = 1'b0;
            func_out[PIN_STROBE] = dir_q[PIN_STROBE];
            func_val[PIN_STROBE] = io_strobe_out;
        end else if (slave) begin
            func_in[PIN_STROBE]  = 1'b1;
        end
        // Pins 2 and 3: select inputs in slave mode only
        if (slave) begin
            func_in[PIN_STROBE+1] = 1'b1;
            func_in[PIN_STROBE+2] = 1'b1;
        end
        // Pin 4: transmit data overrides the port bits
        if (tx_enable && serial_live) begin
            func_out[PIN_TX] = 1'b1;
            func_val[PIN_TX] = sync_serial_tx;
        end
        // Pin 5: receive data keeps only the pull-up
        if (rx_enable && serial_live) begin
            func_in[PIN_RX] = 1'b1;
        end
        // Pin 6: serial clock in either direction
        if (sclk_out_enable && serial_live) begin
            func_out[PIN_SCLK] = 1'b1;
            func_val[PIN_SCLK] = sclk_out_level;
        end else if (sclk_in_enable && serial_live) begin
            func_in[PIN_SCLK]  = 1'b1;
        end
    end

    // ****************************************************************
    // Pin cells
    // ****************************************************************

    // One cell per pin
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        port8_pin_cell u_cell (
            .dir_bit     (dir_q[i]),
            .data_bit    (data_q[i]),
            .func_out    (func_out[i]),
            .func_val    (func_val[i]),
            .func_in     (func_in[i]),
            .gpio_out_ok (gpio_ok[i]),
            .hw_standby  (hw_standby),
            .drive       (cell_drive[i]),
            .level       (cell_level[i]),
            .pull_on     (cell_pullup[i])
        );
    end

    // ****************************************************************
    // Pin output stage
    // ****************************************************************

    // Next pin state; reset leaves all pins as inputs
    always_comb begin
        if (rst) begin
            pin_out_d    = '0;
            pin_oe_n_d   = '1;
            pin_pullup_d = '0;
        end else begin
            pin_out_d    = cell_level;
            pin_oe_n_d   = ~cell_drive;
            pin_pullup_d = cell_pullup;
        end
    end

    // Pin registers
    always_ff @(posedge mclk) begin
        pin_out_q    <= pin_out_d;
        pin_oe_n_q   <= pin_oe_n_d;
        pin_pullup_q <= pin_pullup_d;
    end

    // ****************************************************************
    // Register read path
    // ****************************************************************

    // Read data, held between reads
    always_comb begin
        rdata_d = rdata_q;
        if (rst) begin
            rdata_d = '0;
        end else if (rd_stb && addr == ADDR_DATA) begin
            for (int b = 0; b < PINS; b++) begin
                rdata_d[b] = dir_q[b] ? data_q[b] : pin_in[b];
            end
            rdata_d[RESERVED_BIT] = RESERVED_VALUE;
        end else if (rd_stb && addr == ADDR_DIRECTION) begin
            rdata_d = DIR_READ_VALUE;
        end
    end

    // Read register
    always_ff @(posedge mclk) begin
        rdata_q <= rdata_d;
    end

    // ****************************************************************
    // Alternate inputs to other blocks
    // ****************************************************************

    // Route pin levels to the peripherals that own them
    always_comb begin
        if (rst) begin
            select_d = '0;
            rx_d     = 1'b0;
            sclk_d   = 1'b0;
            irq_d    = '0;
        end else begin
            // Select lines valid only in slave mode
            select_d = slave ? pin_in[SELECT_COUNT-1:0] : '0;
            rx_d     = func_in[PIN_RX] & pin_in[PIN_RX];
            sclk_d   = func_in[PIN_SCLK] & pin_in[PIN_SCLK];
            // Pin level feeds interrupts; driven data shows too
            irq_d    = pin_in[PIN_SCLK:PIN_TX];
        end
    end

    // Alternate input registers
    always_ff @(posedge mclk) begin
        select_q <= select_d;
        rx_q     <= rx_d;
        sclk_q   <= sclk_d;
        irq_q    <= irq_d;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign pin_out           = pin_out_q;
    assign pin_oe_n          = pin_oe_n_q;
    assign pin_pullup        = pin_pullup_q;
    assign rdata             = rdata_q;
    assign slave_reg_select  = select_q;
    assign sync_serial_rx    = rx_q;
    assign sync_serial_clock = sclk_q;
    assign ext_interrupt_3   = irq_q[0];
    assign ext_interrupt_4   = irq_q[1];
    assign ext_interrupt_5   = irq_q[2];

endmodule : port8_pin_mux_gpio

`default_nettype wire

// [logic/port8_regs.sv]
// Purpose: Direction and data registers of the port
// Assumes: One write strobe per access, address stable with it
// Notes:   Reset value of the direction register depends on mode
`timescale 1ns/1ns
`default_nettype none

module port8_regs
    import port8_pkg::*;
#(
    parameter int PINS = PIN_COUNT
) (
    // Clock and reset
    input  wire logic            mclk,
    input  wire logic            rst,
    // Mode at reset
    input  wire logic [1:0]      mode,
    // Write access
    input  wire logic            wr_stb,
    input  wire logic [15:0]     addr,
    input  wire logic [7:0]      wdata,
    // Register contents
    output logic      [PINS-1:0] dir_q,
    output logic      [PINS-1:0] data_q
);

    logic [PINS-1:0] dir_d;
    logic [PINS-1:0] data_d;

    // Reject any width other than PIN_COUNT
    if (PINS != PIN_COUNT) begin : g_check
        $error("port8_regs: PINS must equal PIN_COUNT");
    end

    // Write decode; bit 7 is never stored
    always_comb begin
        dir_d  = dir_q;
        data_d = data_q;
        if (rst) begin
            if (mode == MODE_SINGLE) begin
                dir_d = DIR_RESET_SINGLE[PINS-1:0];
            end else begin
                dir_d = DIR_RESET_EXP[PINS-1:0];
            end
            data_d = DATA_RESET[PINS-1:0];           // Pull-ups off
        end else if (wr_stb && addr == ADDR_DIRECTION) begin
            dir_d  = wdata[PINS-1:0];
        end else if (wr_stb && addr == ADDR_DATA) begin
            data_d = wdata[PINS-1:0];
        end
    end

    // Register stage
    always_ff @(posedge mclk) begin
        dir_q  <= dir_d;
        data_q <= data_d;
    end

endmodule : port8_regs

`default_nettype wire

// [test/port8_board.sv]
// Purpose: Board model around the seven port pins
// Assumes: Bench says which pins outside drivers hold
// Notes:   Undriven pins without pull-up wander each cycle
`timescale 1ns/1ns
`default_nettype none

module port8_board
    import port8_pkg::*;
(
    // Pin side of the port
    input  wire logic                 mclk,
    input  wire logic [PIN_COUNT-1:0] pin_out,
    input  wire logic [PIN_COUNT-1:0] pin_oe_n,
    input  wire logic [PIN_COUNT-1:0] pin_pullup,
    // Outside drivers
    input  wire logic [PIN_COUNT-1:0] ext_en,
    input  wire logic [PIN_COUNT-1:0] ext_val,
    // Resolved levels
    output logic      [PIN_COUNT-1:0] pin_in
);
    logic [PIN_COUNT-1:0] drift_q = 7'h55;

    // Floating level changes every cycle
    always @(posedge mclk) drift_q <= ~drift_q;

    // Port drive wins, then outside driver, then pull-up
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pin_pullup[i]) pin_in[i] = 1'b1;
            else pin_in[i] = drift_q[i];
        end
    end
endmodule : port8_board
`default_nettype wire

// [test/port8_pin_mux_gpio_chk.sv]
// Purpose: Port-level properties of the seven-pin port
// Assumes: Only top-level ports are visible
// Notes:   Attached by bind below the module
`timescale 1ns/1ns
`default_nettype none

module port8_pin_mux_gpio_chk
    import port8_pkg::*;
#(
    parameter int PINS = PIN_COUNT
) (
    // Clock, reset and state
    input wire logic                    mclk,
    input wire logic                    rst,
    input wire logic [1:0]              mode,
    input wire logic                    dual_port_ram_enable,
    input wire logic                    hw_standby,
    input wire logic                    sw_standby,
    // Register bus
    input wire logic [15:0]             addr,
    input wire logic                    rd_stb,
    input wire logic [7:0]              rdata,
    // Serial controls
    input wire logic                    tx_enable,
    input wire logic                    sync_serial_tx,
    input wire logic                    rx_enable,
    input wire logic                    sclk_out_enable,
    input wire logic                    sclk_out_level,
    // Pins and routed inputs
    input wire logic [PINS-1:0]         pin_in,
    input wire logic [PINS-1:0]         pin_out,
    input wire logic [PINS-1:0]         pin_oe_n,
    input wire logic [PINS-1:0]         pin_pullup,
    input wire logic [SELECT_COUNT-1:0] slave_reg_select,
    input wire logic                    sync_serial_rx
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // Reset and hardware standby float the pins
    chk_reset_float: assert property (disable iff (1'b0)
        rst ##1 rst |-> (&pin_oe_n) && (pin_pullup == '0))
        else $error("pins not floating in reset");
    chk_hw_float: assert property (hw_standby |=>
        (&pin_oe_n) && (pin_pullup == '0))
        else $error("pins not floating in standby");
    // Register reads
    chk_dir_reads: assert property (rd_stb && addr == ADDR_DIRECTION
        |=> rdata == DIR_READ_VALUE) else $error("direction read wrong");
    chk_bit7_one: assert property (rd_stb && addr == ADDR_DATA
        |=> rdata[RESERVED_BIT] == RESERVED_VALUE) else $error("bit 7 low");
    // Serial, E clock and select functions own their pins
    chk_tx_owns: assert property (tx_enable && !hw_standby && !sw_standby
        |=> !pin_oe_n[PIN_TX] && !pin_pullup[PIN_TX]
        && pin_out[PIN_TX] == $past(sync_serial_tx)) else $error("tx pin");
    chk_rx_route: assert property (rx_enable && !hw_standby && !sw_standby
        |=> pin_oe_n[PIN_RX] && sync_serial_rx == $past(pin_in[PIN_RX]))
        else $error("rx pin");
    chk_sclk_drive: assert property (sclk_out_enable && !hw_standby
        && !sw_standby |=> !pin_oe_n[PIN_SCLK]
        && pin_out[PIN_SCLK] == $past(sclk_out_level)) else $error("sclk");
    chk_eclk_low: assert property (sw_standby && !hw_standby
        && mode != MODE_SINGLE |=> pin_oe_n[PIN_ECLK] || !pin_out[PIN_ECLK])
        else $error("E clock not low");
    chk_slave_sel: assert property (mode == MODE_SINGLE
        && dual_port_ram_enable && !hw_standby |=> pin_oe_n[3:0] == 4'hF
        && slave_reg_select == $past(pin_in[3:0])) else $error("select");
endmodule : port8_pin_mux_gpio_chk

bind port8_pin_mux_gpio port8_pin_mux_gpio_chk #(.PINS(PINS)) u_chk (
    .mclk, .rst, .mode, .dual_port_ram_enable, .hw_standby, .sw_standby,
    .addr, .rd_stb, .rdata, .tx_enable, .sync_serial_tx, .rx_enable,
    .sclk_out_enable, .sclk_out_level, .pin_in, .pin_out, .pin_oe_n,
    .pin_pullup, .slave_reg_select, .sync_serial_rx);
`default_nettype wire

// [test/port8_pin_mux_gpio_tb_top.sv]
// Purpose: Self-checking bench for the seven-pin port
// Assumes: Board model resolves the pin levels
// Notes:   Reads are queued and compared by a monitor
`timescale 1ns/1ns
`default_nettype none

module port8_pin_mux_gpio_tb_top
    import port8_pkg::*;
;
    // Stimulus and observed signals
    logic       mclk = 1'b0, rst = 1'b1, dual_port_ram_enable = 1'b0;
    logic [1:0] mode = MODE_EXPANDED_1;
    logic       hw_standby = 1'b0, sw_standby = 1'b0, rd_seen = 1'b0;
    logic       wr_stb = 1'b0, rd_stb = 1'b0, e_clock = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00, rdata, exp_q[$];
    logic       io_strobe_out = 1'b0, tx_enable = 1'b0, rx_enable = 1'b0;
    logic       sync_serial_tx = 1'b1, sclk_out_level = 1'b0;
    logic       sclk_out_enable = 1'b0, sclk_in_enable = 1'b0;
    logic [6:0] pin_in, pin_out, pin_oe_n, pin_pullup, mdir, mdat;
    logic [6:0] ext_en = 7'h00, ext_val = 7'h55;
    logic [3:0] slave_reg_select;
    logic       sync_serial_rx, sync_serial_clock;
    logic       ext_interrupt_3, ext_interrupt_4, ext_interrupt_5;
    int         failures = 0, n_checks = 0, cycles = 0;

    port8_pin_mux_gpio u_port8_pin_mux_gpio (
        .mclk, .rst, .mode, .dual_port_ram_enable, .hw_standby, .sw_standby,
        .addr, .wr_stb, .rd_stb, .wdata, .rdata, .e_clock, .io_strobe_out,
        .tx_enable, .sync_serial_tx, .rx_enable, .sclk_out_enable,
        .sclk_in_enable, .sclk_out_level, .pin_in, .pin_out, .pin_oe_n,
        .pin_pullup, .slave_reg_select, .sync_serial_rx, .sync_serial_clock,
        .ext_interrupt_3, .ext_interrupt_4, .ext_interrupt_5);
    port8_board u_port8_board (.mclk, .pin_out, .pin_oe_n, .pin_pullup,
        .ext_en, .ext_val, .pin_in);

    // Clock and hang guard
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            $display("MISMATCH cycles exp 3999 got %0d", cycles);
            stop_test();
        end
    end

    // Compare tasks and verdict
    task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask : chk_byte
    task automatic chk_pins(string what, logic [6:0] exp, logic [6:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask : chk_pins
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    // Bus cycles at the falling edge
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(negedge mclk);
        addr = a;
        wdata = d;
        wr_stb = 1'b1;
        @(negedge mclk);
        wr_stb = 1'b0;
        if (a == ADDR_DIRECTION) mdir = d[6:0];
        if (a == ADDR_DATA) mdat = d[6:0];
    endtask : wr
    task automatic rd(logic [15:0] a, logic [7:0] e);
        @(negedge mclk);
        addr = a;
        rd_stb = 1'b1;
        exp_q.push_back(e);
        @(negedge mclk);
        rd_stb = 1'b0;
    endtask : rd
    function automatic logic [7:0] exp_rd(logic [6:0] lvl);
        return {1'b1, (mdir & mdat) | (~mdir & lvl)};
    endfunction : exp_rd
    task automatic settle();
        repeat (3) @(negedge mclk);
    endtask : settle
    task automatic pins(logic [6:0] oe_n, logic [6:0] pu);
        chk_pins("pin_oe_n", oe_n, pin_oe_n);
        chk_pins("pin_pullup", pu, pin_pullup);
    endtask : pins
    task automatic do_reset(logic [1:0] m);
        @(negedge mclk);
        mode = m;
        rst = 1'b1;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        mdir = (m == MODE_SINGLE) ? DIR_RESET_SINGLE[6:0] : DIR_RESET_EXP[6:0];
        mdat = DATA_RESET[6:0];
        settle();
    endtask : do_reset

    // Read monitor takes the oldest note
    always @(posedge mclk) rd_seen <= rd_stb;
    always @(negedge mclk) begin
        if (rd_seen) chk_byte("rdata", exp_q.pop_front(), rdata);
    end

    // Main sequence
    initial begin
        void'($urandom(32'h5821));
        ext_en = 7'h7E;
        do_reset(MODE_EXPANDED_1);
        pins(7'h7E, 7'h00);
        chk_pins("eclk", {6'h0, e_clock}, {6'h0, pin_out[0]});
        rd(ADDR_DIRECTION, DIR_READ_VALUE);
        rd(ADDR_DATA, exp_rd(ext_val));
        ext_en = 7'h7C;
        io_strobe_out = 1'b1;
        wr(ADDR_DIRECTION, 8'h03);
        wr(ADDR_DATA, 8'h7F);
        settle();
        pins(7'h7C, 7'h7C);
        chk_pins("alt", {io_strobe_out, e_clock}, pin_out[1:0]);
        rd(ADDR_DATA, exp_rd(ext_val));
        wr(ADDR_DATA, 8'h00);
        settle();
        pins(7'h7C, 7'h00);
        rd(ADDR_DATA, exp_rd(ext_val));
        // Serial functions take pins 4 to 6
        {tx_enable, rx_enable, sclk_out_enable} = 3'h7;
        ext_en = 7'h2C;
        ext_val = 7'h2A;
        wr(ADDR_DIRECTION, 8'h23);
        wr(ADDR_DATA, 8'h70);
        settle();
        pins(7'h2C, 7'h00);
        chk_pins("ser", {sclk_out_level, sync_serial_tx},
            {pin_out[6], pin_out[4]});
        chk_pins("rx", ext_val[5], sync_serial_rx);
        rd(ADDR_DATA, exp_rd({sclk_out_level, ext_val[5],
            sync_serial_tx, ext_val[3:0]}));
        wr(ADDR_DIRECTION, 8'h03);
        settle();
        pins(7'h2C, 7'h20);
        // Software then hardware standby
        sw_standby = 1'b1;
        ext_en = 7'h7C;
        settle();
        pins(7'h7C, 7'h70);
        chk_pins("eclk_low", 7'h00, {6'h0, pin_out[0]});
        rd(ADDR_DATA, exp_rd(ext_val));
        sw_standby = 1'b0;
        {tx_enable, rx_enable, sclk_out_enable} = 3'h0;
        hw_standby = 1'b1;
        settle();
        pins(7'h7F, 7'h00);
        hw_standby = 1'b0;
        // Single-chip port pins
        ext_en = 7'h7F;
        do_reset(MODE_SINGLE);
        pins(7'h7F, 7'h00);
        repeat (8) begin
            ext_val = 7'($urandom);
            wr(ADDR_DIRECTION, 8'($urandom));
            ext_en = ~mdir;
            wr(ADDR_DATA, 8'($urandom));
            wr(16'hFFBE, 8'($urandom));
            settle();
            pins(~mdir, ~mdir & mdat);
            chk_pins("gpio", mdir & mdat, mdir & pin_out);
            rd(ADDR_DATA, exp_rd(ext_val));
        end
        // Slave selects, clock input, interrupts
        dual_port_ram_enable = 1'b1;
        sclk_in_enable = 1'b1;
        ext_val = 7'($urandom);
        ext_en = 7'h7F;
        wr(ADDR_DIRECTION, 8'h0A);
        wr(ADDR_DATA, 8'h0F);
        settle();
        pins(7'h7F, 7'h05);
        chk_pins("sel", ext_val[3:0], slave_reg_select);
        chk_pins("sclk_in", ext_val[6], sync_serial_clock);
        chk_pins("irq", ext_val[6:4], {ext_interrupt_5,
            ext_interrupt_4, ext_interrupt_3});
        rd(ADDR_DATA, exp_rd(ext_val));
        repeat (4) @(negedge mclk);
        stop_test();
    end
endmodule : port8_pin_mux_gpio_tb_top
`default_nettype wire
